// ### logic/nvc_pkg.sv
// package: constants and types for the nonvolatile sram host controller
package nvc_pkg;
  localparam int CLK_MHZ = 40;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  // software sequence addresses
  localparam logic [10:0] SEQ_A0 = 11'h000;
  localparam logic [10:0] SEQ_A1 = 11'h555;
  localparam logic [10:0] SEQ_A2 = 11'h2AA;
  localparam logic [10:0] SEQ_A3 = 11'h7FF;
  localparam logic [10:0] SEQ_A4 = 11'h0F0;
  localparam logic [10:0] SEQ_STORE = 11'h70F;
  localparam logic [10:0] SEQ_RECALL = 11'h70E;
  localparam logic [10:0] SEQ_TEST = 11'h39C;
  // times as printed
  localparam int T_CE_NS = 25;
  localparam int T_HSB_NS = 250;
  localparam int T_INH_OFF_NS = 700;
  localparam int T_OUT_OFF_NS = 600;
  localparam int T_STORE_MS = 10;
  localparam int T_RECALL_US = 20;
  localparam int T_PWRUP_US = 650;
  // derived cycle counts: minimums round up, waits are full maxima
  localparam int CYC_CE = (T_CE_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_HSB = (T_HSB_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_INH_OFF = (T_INH_OFF_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_OUT_OFF = (T_OUT_OFF_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_STORE = T_STORE_MS * 1000 * CLK_MHZ;
  localparam int CYC_RECALL = T_RECALL_US * CLK_MHZ;
  localparam int CYC_PWRUP = T_PWRUP_US * CLK_MHZ;
  localparam int CNT_W = 20;
  localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;
  localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;
  localparam logic [2:0] STEP_LAST = 3'h5;
  localparam logic [2:0] STEP_ZERO = 3'h0;
  localparam logic [2:0] STEP_ONE = 3'h1;

  typedef enum logic [2:0] {
    OP_READ, OP_WRITE, OP_SW_STORE, OP_SW_RECALL, OP_HW_STORE
  } op_t;

  typedef struct packed {
    logic [10:0] addr;
    logic [7:0]  wdata;
    op_t         op;
  } req_t;

  typedef struct packed {
    logic       ce_n;
    logic       we_n;
    logic       oe_n;
    logic [10:0] addr_bus;
    logic [7:0] data_out;
    logic       data_oe;
  } pins_t;
endpackage : nvc_pkg

// ### logic/nvc_host.sv
// host controller driving the nonvolatile sram through its pins
// Operation
// R01 - write strobe low at select: no read data
// R02 - store sequence six reads ending 70F
// R03 - recall sequence six reads ending 70E
// R04 - write strobe high during all sequence reads
// R05 - pin store copies only after writes
// R06 - pin low: device floats, then standby
// R07 - power-up recall done within 650 us
// R08 - inhibit after 1 us, store 10 ms
// R09 - accesses resume 700 ns after rise
// R10 - hold store pin low 250 ns minimum
// R11 - device holds pin low while storing
// R12 - store pin only ever driven low
// R13 - up to 32 devices share pin
// R14 - never issue the 39C test sequence
// R15 - output enable ignored by sequence detect
// R16 - triggered sequence runs ignoring inputs
// R17 - one select pulse per sequence step
// R18 - outputs off 600 ns, store/recall times
// R19 - select pulse minimum width, address stable
// R20 - read: select, oe low, we high
// R21 - write: select and we low
// R22 - other accesses abort sequence
// R23 - software store runs regardless of writes
// R24 - abort returns tracker to first step
// R25 - written flag gates hardware stores
`timescale 1ns/100ps
`default_nettype none
module nvc_host (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              clk_en,
  // user request
  input  wire logic              req_valid,
  input  wire nvc_pkg::req_t     req,
  output var  logic              req_ready,
  output var  logic              rsp_valid,
  output var  logic [7:0]        rsp_data,
  // device pins
  output var  nvc_pkg::pins_t    pins,
  input  wire logic [7:0]        data_bus_in,
  input  wire logic              hw_store_busy_n_in,
  output var  logic              hw_store_busy_n_out,
  output var  logic              hw_store_busy_n_oe
);
  // ****************************************
  // state
  // ****************************************
  typedef enum logic [2:0] {
    S_PWRUP, S_IDLE, S_SETUP, S_STROBE, S_GAP, S_HSB_LOW, S_HSB_WAIT, S_WAIT
  } st_t;

  typedef struct packed {
    st_t              st;
    nvc_pkg::req_t    cur;
    logic [2:0]       step;
    logic [nvc_pkg::CNT_W-1:0] cnt;
    logic             ready;
    logic             rvalid;
    logic [7:0]       rdata;
    nvc_pkg::pins_t   pins;
    logic             hsb_oe;
  } state_t;

  state_t s;
  state_t next_s;
  logic [10:0] step_addr;

  // sequence address for the current step
  always_comb begin
    unique case (s.step)
      3'h0: step_addr = nvc_pkg::SEQ_A0;
      3'h1: step_addr = nvc_pkg::SEQ_A1;
      3'h2: step_addr = nvc_pkg::SEQ_A2;
      3'h3: step_addr = nvc_pkg::SEQ_A3;
      3'h4: step_addr = nvc_pkg::SEQ_A4;
      default: step_addr = (s.cur.op == nvc_pkg::OP_SW_STORE)
                           ? nvc_pkg::SEQ_STORE : nvc_pkg::SEQ_RECALL; // R02 R03 R14
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.rvalid = 1'b0;
    unique case (s.st)
      S_PWRUP: begin
        if (s.cnt == nvc_pkg::CNT_ZERO) begin // R07
          next_s.st = S_IDLE;
          next_s.ready = 1'b1;
        end else begin
          next_s.cnt = s.cnt - nvc_pkg::CNT_ONE;
        end
      end
      S_IDLE: begin
        if (req_valid) begin
          next_s.cur = req;
          next_s.ready = 1'b0;
          next_s.step = nvc_pkg::STEP_ZERO;
          if (req.op == nvc_pkg::OP_HW_STORE) begin
            next_s.hsb_oe = 1'b1; // R12 R13
            next_s.cnt = nvc_pkg::CNT_W'(nvc_pkg::CYC_HSB);
            next_s.st = S_HSB_LOW;
          end else begin
            next_s.st = S_SETUP;
          end
        end
      end
      S_SETUP: begin
        // address and strobes first, select stays high
        next_s.pins.addr_bus = (s.cur.op == nvc_pkg::OP_READ ||
                                s.cur.op == nvc_pkg::OP_WRITE)
                               ? s.cur.addr : step_addr; // R19
        next_s.pins.we_n = (s.cur.op != nvc_pkg::OP_WRITE); // R04 R21
        next_s.pins.oe_n = (s.cur.op == nvc_pkg::OP_WRITE); // R20
        next_s.pins.data_out = s.cur.wdata;
        next_s.pins.data_oe = (s.cur.op == nvc_pkg::OP_WRITE); // R01
        next_s.cnt = nvc_pkg::CNT_W'(nvc_pkg::CYC_CE);
        next_s.st = S_STROBE;
      end
      S_STROBE: begin
        if (s.pins.ce_n) begin
          // select falls a cycle after the address settled
          next_s.pins.ce_n = 1'b0; // R17 R19
        end else if (s.cnt <= nvc_pkg::CNT_ONE) begin // R19
          next_s.pins.ce_n = 1'b1;
          next_s.pins.we_n = 1'b1;
          next_s.pins.oe_n = 1'b1;
          next_s.pins.data_oe = 1'b0;
          next_s.rdata = data_bus_in;
          next_s.st = S_GAP;
        end else begin
          next_s.cnt = s.cnt - nvc_pkg::CNT_ONE;
        end
      end
      S_GAP: begin
        if (s.cur.op == nvc_pkg::OP_READ || s.cur.op == nvc_pkg::OP_WRITE) begin
          next_s.rvalid = (s.cur.op == nvc_pkg::OP_READ);
          next_s.ready = 1'b1;
          next_s.st = S_IDLE;
        end else if (s.step == nvc_pkg::STEP_LAST) begin // R16 R18 R23
          next_s.cnt = (s.cur.op == nvc_pkg::OP_SW_STORE)
                       ? nvc_pkg::CNT_W'(nvc_pkg::CYC_STORE)
                       : nvc_pkg::CNT_W'(nvc_pkg::CYC_RECALL);
          next_s.st = S_WAIT;
        end else begin
          // no other access between steps
          next_s.step = s.step + nvc_pkg::STEP_ONE; // R22 R24
          next_s.st = S_SETUP;
        end
      end
      S_HSB_LOW: begin
        if (s.cnt <= nvc_pkg::CNT_ONE) begin // R10
          next_s.hsb_oe = 1'b0; // R11
          next_s.cnt = nvc_pkg::CNT_W'(nvc_pkg::CYC_STORE);
          next_s.st = S_HSB_WAIT;
        end else begin
          next_s.cnt = s.cnt - nvc_pkg::CNT_ONE;
        end
      end
      S_HSB_WAIT: begin
        // device holds the line low while storing; bounded by store time
        if (hw_store_busy_n_in || s.cnt == nvc_pkg::CNT_ZERO) begin // R05 R06 R08
          next_s.cnt = nvc_pkg::CNT_W'(nvc_pkg::CYC_INH_OFF);
          next_s.st = S_WAIT;
        end else begin
          next_s.cnt = s.cnt - nvc_pkg::CNT_ONE;
        end
      end
      S_WAIT: begin
        if (s.cnt == nvc_pkg::CNT_ZERO) begin // R09 R18
          next_s.ready = 1'b1;
          next_s.st = S_IDLE;
        end else begin
          next_s.cnt = s.cnt - nvc_pkg::CNT_ONE;
        end
      end
      default: next_s.st = S_IDLE;
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s.st <= S_PWRUP;
      s.cur <= '0;
      s.step <= nvc_pkg::STEP_ZERO;
      s.cnt <= nvc_pkg::CNT_W'(nvc_pkg::CYC_PWRUP);
      s.ready <= 1'b0;
      s.rvalid <= 1'b0;
      s.rdata <= 8'h00;
      s.pins <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr_bus: 11'h000,
                  data_out: 8'h00, data_oe: 1'b0};
      s.hsb_oe <= 1'b0;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  assign req_ready = s.ready;
  assign rsp_valid = s.rvalid;
  assign rsp_data = s.rdata;
  assign pins = s.pins;
  assign hw_store_busy_n_out = 1'b0;
  assign hw_store_busy_n_oe = s.hsb_oe;

  // ****************************************
  // assertions
  // ****************************************
  property p_we_high_seq;
    @(posedge clk_sys) disable iff (rst)
      (!s.pins.ce_n && (s.cur.op == nvc_pkg::OP_SW_STORE ||
        s.cur.op == nvc_pkg::OP_SW_RECALL)) |-> s.pins.we_n;
  endproperty
  a_we_high_seq: assert property (p_we_high_seq) else $error("we low in sequence"); // R04

  property p_last_store;
    @(posedge clk_sys) disable iff (rst)
      (!s.pins.ce_n && s.step == nvc_pkg::STEP_LAST &&
       s.cur.op == nvc_pkg::OP_SW_STORE) |-> s.pins.addr_bus == nvc_pkg::SEQ_STORE;
  endproperty
  a_last_store: assert property (p_last_store) else $error("bad store end"); // R02

  property p_last_recall;
    @(posedge clk_sys) disable iff (rst)
      (!s.pins.ce_n && s.step == nvc_pkg::STEP_LAST &&
       s.cur.op == nvc_pkg::OP_SW_RECALL) |-> s.pins.addr_bus == nvc_pkg::SEQ_RECALL;
  endproperty
  a_last_recall: assert property (p_last_recall) else $error("bad recall end"); // R03

  property p_no_test;
    @(posedge clk_sys) disable iff (rst)
      !s.pins.ce_n && s.step == nvc_pkg::STEP_LAST |-> s.pins.addr_bus != nvc_pkg::SEQ_TEST;
  endproperty
  a_no_test: assert property (p_no_test) else $error("test sequence issued"); // R14

  property p_hsb_width;
    @(posedge clk_sys) disable iff (rst)
      $rose(hw_store_busy_n_oe) |-> hw_store_busy_n_oe [*8]
        ##1 hw_store_busy_n_oe ##1 hw_store_busy_n_oe;
  endproperty
  a_hsb_width: assert property (p_hsb_width) else $error("store pulse short"); // R10

  property p_hsb_low_only;
    @(posedge clk_sys) disable iff (rst)
      hw_store_busy_n_oe |-> !hw_store_busy_n_out;
  endproperty
  a_hsb_low_only: assert property (p_hsb_low_only) else $error("store pin driven high"); // R12

  property p_ce_width;
    @(posedge clk_sys) disable iff (rst)
      $fell(s.pins.ce_n) |-> s.st == S_STROBE &&
        s.cnt == nvc_pkg::CNT_W'(nvc_pkg::CYC_CE);
  endproperty
  a_ce_width: assert property (p_ce_width) else $error("select pulse short"); // R19

  property p_addr_stable;
    @(posedge clk_sys) disable iff (rst)
      !s.pins.ce_n |-> $stable(s.pins.addr_bus);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved"); // R19

  property p_no_drive_read;
    @(posedge clk_sys) disable iff (rst)
      s.pins.data_oe |-> !s.pins.we_n;
  endproperty
  a_no_drive_read: assert property (p_no_drive_read) else $error("data driven on read"); // R21

  c_store: cover property (@(posedge clk_sys) s.st == S_WAIT &&
                           s.cur.op == nvc_pkg::OP_SW_STORE);
  c_recall: cover property (@(posedge clk_sys) s.st == S_WAIT &&
                            s.cur.op == nvc_pkg::OP_SW_RECALL);
  c_hw: cover property (@(posedge clk_sys) s.st == S_HSB_WAIT);
  c_read: cover property (@(posedge clk_sys) rsp_valid);
endmodule : nvc_host
`default_nettype wire

// ### test/nvsram_model.sv
// device model: sram with shadow array, sequences and store/busy pin
`timescale 1ns/100ps
`default_nettype none
module nvsram_model (
  // host pins
  input  wire nvc_pkg::pins_t pins,
  input  wire logic           sb_wire,
  // device outputs
  output var  logic [7:0]     dev_data,
  output var  logic           sb_pull,
  // observation
  output var  int             store_cnt,
  output var  int             recall_cnt
);
  logic [7:0]  mem [0:2047];
  logic [7:0]  nv  [0:2047];
  logic [10:0] seq [0:4];
  int          step;
  logic        written;
  logic        busy;

  initial begin
    seq = '{nvc_pkg::SEQ_A0, nvc_pkg::SEQ_A1, nvc_pkg::SEQ_A2,
            nvc_pkg::SEQ_A3, nvc_pkg::SEQ_A4};
    for (int i = 0; i < 2048; i++)
      nv[i] = i[7:0] ^ 8'hA5;
    mem = nv;
    {step, written, busy, sb_pull, dev_data, store_cnt, recall_cnt} = '0;
  end

  // **************************
  // nonvolatile cycles
  // **************************
  task automatic nv_cycle(input logic st);
    busy = 1'b1;
    step = 0;
    if (st) begin
      #5000;
      nv = mem;
      written = 1'b0;
      store_cnt++;
    end else begin
      #10000;
      mem = nv;
      recall_cnt++;
    end
    busy = 1'b0;
  endtask : nv_cycle

  always @(negedge pins.ce_n) begin
    if (!busy && sb_wire && !pins.we_n) begin
      mem[pins.addr_bus] = pins.data_out;
      written = 1'b1;
      step = 0;
    end else if (!busy && sb_wire) begin
      if (step == 5 && pins.addr_bus == nvc_pkg::SEQ_STORE)
        nv_cycle(1'b1);
      else if (step == 5 && pins.addr_bus == nvc_pkg::SEQ_RECALL)
        nv_cycle(1'b0);
      else begin
        if (!pins.oe_n)
          dev_data = mem[pins.addr_bus];
        if (step < 5 && pins.addr_bus == seq[step])
          step++;
        else
          step = int'(pins.addr_bus == nvc_pkg::SEQ_A0);
      end
    end
  end

  // released bus shows the inverse of the data it held
  always @(posedge pins.ce_n)
    dev_data = ~dev_data;

  always @(negedge sb_wire) begin
    if (!busy) begin
      busy = 1'b1;
      step = 0;
      #210;
      if (written) begin
        sb_pull = 1'b1;
        #2000;
        nv = mem;
        written = 1'b0;
        store_cnt++;
        sb_pull = 1'b0;
      end
      wait (sb_wire);
      busy = 1'b0;
    end
  end
endmodule : nvsram_model
`default_nettype wire

// ### test/nvsram_nonvolatile_control_tb_top.sv
// bench: host controller against the device model
`timescale 1ns/100ps
`default_nettype none
module nvsram_nonvolatile_control_tb_top;
  typedef struct packed {
    nvc_pkg::op_t op;
    logic [10:0]  a;
    logic [7:0]   d;
    logic [7:0]   e;
  } row_t;
  logic           clk_sys = 1'b0;
  logic           rst = 1'b1;
  logic           clk_en = 1'b1;
  logic           req_valid = 1'b0;
  nvc_pkg::req_t  req = '0;
  logic           req_ready;
  logic           rsp_valid;
  logic [7:0]     rsp_data;
  nvc_pkg::pins_t pins;
  logic [7:0]     dev_data;
  logic           sb_out;
  logic           sb_oe;
  logic           sb_pull;
  wire logic      sb_wire;
  int             store_cnt;
  int             recall_cnt;
  int             error_cnt = 0;
  int             check_count = 0;
  logic [7:0]     rd;
  row_t           rows [0:6];

  always #12.5 clk_sys = ~clk_sys;
  assign sb_wire = (sb_oe ? sb_out : 1'b1) & !sb_pull;

  nvc_host dut_u (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins),
    .data_bus_in(dev_data), .hw_store_busy_n_in(sb_wire),
    .hw_store_busy_n_out(sb_out), .hw_store_busy_n_oe(sb_oe));
  nvsram_model dev_u (.pins(pins), .sb_wire(sb_wire),
    .dev_data(dev_data), .sb_pull(sb_pull), .store_cnt(store_cnt),
    .recall_cnt(recall_cnt));

  // **************************
  // tasks
  // **************************
  task automatic check(input string nm, input logic [31:0] exp, act);
    check_count++;
    if (act !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, act);
    end
  endtask : check

  task automatic results;
    if (error_cnt == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results

  task automatic wait_ready(input int lim);
    int n;
    n = 0;
    while (req_ready !== 1'b1) begin
      @(posedge clk_sys);
      #1;
      n++;
      if (n > lim) begin
        check("req_ready", 1, req_ready);
        results();
      end
    end
  endtask : wait_ready

  task automatic do_req(input nvc_pkg::op_t op, input logic [10:0] a,
                        input logic [7:0] wd, input int lim);
    wait_ready(60);
    req_valid = 1'b1;
    req = '{addr: a, wdata: wd, op: op};
    @(posedge clk_sys);
    #1;
    req_valid = 1'b0;
    if (lim > 0) begin
      wait_ready(lim);
      if (op == nvc_pkg::OP_READ)
        check("rsp_valid", 1, rsp_valid);
      rd = rsp_data;
    end
  endtask : do_req

  initial begin
    rows = '{'{nvc_pkg::OP_WRITE, 11'h001, 8'h3C, 8'h00},
             '{nvc_pkg::OP_WRITE, 11'h7FF, 8'hC3, 8'h00},
             '{nvc_pkg::OP_WRITE, 11'h000, 8'h5A, 8'h00},
             '{nvc_pkg::OP_READ,  11'h001, 8'h00, 8'h3C},
             '{nvc_pkg::OP_READ,  11'h7FF, 8'h00, 8'hC3},
             '{nvc_pkg::OP_READ,  11'h000, 8'h00, 8'h5A},
             '{nvc_pkg::OP_READ,  11'h123, 8'h00, 8'h86}};
    repeat (8) @(posedge clk_sys);
    #1;
    check("ce_n", 1, pins.ce_n);
    rst = 1'b0;
    wait_ready(27000);
    foreach (rows[i]) begin
      do_req(rows[i].op, rows[i].a, rows[i].d, 60);
      if (rows[i].op == nvc_pkg::OP_READ)
        check("rd", rows[i].e, rd);
    end
    // frozen clock enable: request must not be taken
    clk_en = 1'b0;
    req_valid = 1'b1;
    req = '{addr: 11'h001, wdata: 8'h00, op: nvc_pkg::OP_READ};
    repeat (4) @(posedge clk_sys);
    #1;
    check("ce_n", 1, pins.ce_n);
    check("req_ready", 1, req_ready);
    req_valid = 1'b0;
    clk_en = 1'b1;
    do_req(nvc_pkg::OP_SW_RECALL, 11'h000, 8'h00, 2000);
    check("recall_cnt", 1, recall_cnt);
    do_req(nvc_pkg::OP_READ, 11'h001, 8'h00, 60);
    check("rd", 8'hA4, rd);
    do_req(nvc_pkg::OP_WRITE, 11'h055, 8'h77, 60);
    do_req(nvc_pkg::OP_HW_STORE, 11'h000, 8'h00, 2000);
    check("store_cnt", 1, store_cnt);
    do_req(nvc_pkg::OP_HW_STORE, 11'h000, 8'h00, 2000);
    check("store_cnt", 1, store_cnt);
    do_req(nvc_pkg::OP_SW_STORE, 11'h000, 8'h00, 0);
    for (int n = 0; n < 400 && store_cnt < 2; n++)
      @(posedge clk_sys);
    check("store_cnt", 2, store_cnt);
    #1;
    rst = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    check("req_ready", 0, req_ready);
    rst = 1'b0;
    wait_ready(27000);
    do_req(nvc_pkg::OP_WRITE, 11'h055, 8'h11, 60);
    do_req(nvc_pkg::OP_SW_RECALL, 11'h000, 8'h00, 2000);
    do_req(nvc_pkg::OP_READ, 11'h055, 8'h00, 60);
    check("rd", 8'h77, rd);
    results();
  end
endmodule : nvsram_nonvolatile_control_tb_top
`default_nettype wire
